//--- design/maint_pkg.sv
// Purpose: shared constants and types for the maintenance bus ends
// Assumes: one system clock for both ends
// Notes: chain layouts are fixed here and used by the module end only
package maint_pkg;
    localparam int NUM_CARDS = 2;
    localparam int CARD_W = 1;
    localparam int ERR_KINDS = 4;
    localparam int FUNC_W = 8;
    localparam int STATE_W = 4;
    localparam int ARG_W = 8;
    // Data chain: function value at the bottom, error bits next, gated state on top
    localparam int FUNC_POS = 0;
    localparam int ERR_POS = FUNC_W;
    localparam int STATE_POS = FUNC_W + ERR_KINDS;
    localparam int DATA_LEN = FUNC_W + ERR_KINDS + STATE_W;
    // Maintenance chain: compare value, stop enable toggle, error-stop suppress
    localparam int CMP_POS = 0;
    localparam int STOP_EN_POS = FUNC_W;
    localparam int NO_FREEZE_POS = FUNC_W + 1;
    localparam int MAINT_LEN = FUNC_W + 2;
    localparam logic CHAIN_DATA = 1'h0;
    localparam logic CHAIN_MAINT = 1'h1;
    localparam logic [ARG_W-1:0] FREQ_RESET = 8'h00;
    typedef enum logic [2:0] {
        op_nop, op_run, op_halt, op_step, op_shift, op_clr_module, op_clr_chain, op_set_mode
    } op_type;
endpackage : maint_pkg

//--- design/maint_bus_if.sv
// Purpose: backplane maintenance bus between controller and module
// Assumes: the fast and the slow bus carry the same logical signals
// Notes: every signal is point to point and driven from a flip-flop
`timescale 1ns/1ps
interface maint_bus_if;
    logic [maint_pkg::NUM_CARDS-1:0] card_clk_en;
    logic shift_en;
    logic clr_module;
    logic clr_chain;
    logic chain_sel;
    logic [maint_pkg::CARD_W-1:0] card_sel;
    logic serial_in;
    logic serial_out;
    logic error_int;
    logic stop_and;
    logic stop_or;
    modport dev (
        input card_clk_en, shift_en, clr_module, clr_chain, chain_sel, card_sel, serial_in,
        output serial_out, error_int, stop_and, stop_or
    );
    modport ctl (
        output card_clk_en, shift_en, clr_module, clr_chain, chain_sel, card_sel, serial_in,
        input serial_out, error_int, stop_and, stop_or
    );
endinterface : maint_bus_if

//--- design/maint_card.sv
// Purpose: one processor card with its data chain and maintenance chain
// Assumes: controls arrive from the module on the same clock
// Notes: the monitored function is a card counter advanced by the card clock
`timescale 1ns/1ps
module maint_card (
    input wire logic clock,
    input wire logic rst,
    input wire logic ce,
    input wire logic run,
    input wire logic shift_data,
    input wire logic shift_maint,
    input wire logic clr_data,
    input wire logic clr_maint,
    input wire logic sin,
    input wire logic [maint_pkg::ERR_KINDS-1:0] err_detect,
    input wire logic [maint_pkg::STATE_W-1:0] state_in,
    output logic data_tail,
    output logic maint_tail,
    output logic err_any,
    output logic stop_hit,
    output logic no_freeze
);
    logic [maint_pkg::DATA_LEN-1:0] data_ff;
    logic [maint_pkg::DATA_LEN-1:0] nxt_data;
    logic [maint_pkg::MAINT_LEN-1:0] maint_ff;
    logic [maint_pkg::MAINT_LEN-1:0] nxt_maint;
    logic [maint_pkg::ERR_KINDS-1:0] err_bits;
    logic [maint_pkg::FUNC_W-1:0] func_val;

    assign err_bits = data_ff[maint_pkg::ERR_POS +: maint_pkg::ERR_KINDS];
    assign func_val = data_ff[maint_pkg::FUNC_POS +: maint_pkg::FUNC_W];

    // Next chain contents; a clear hides an error seen in the same cycle only while the card clock is stopped
    always_comb begin
        nxt_data = data_ff;
        nxt_maint = maint_ff;
        if (clr_data) begin
            nxt_data = '0;
        end else if (shift_data) begin
            nxt_data = {data_ff[maint_pkg::DATA_LEN-2:0], sin};
        end else if (run) begin
            nxt_data[maint_pkg::FUNC_POS +: maint_pkg::FUNC_W] = func_val + 8'h01;
            nxt_data[maint_pkg::STATE_POS +: maint_pkg::STATE_W] = state_in;
        end
        if (run && !shift_data) begin
            nxt_data[maint_pkg::ERR_POS +: maint_pkg::ERR_KINDS] =
                nxt_data[maint_pkg::ERR_POS +: maint_pkg::ERR_KINDS] | err_detect;
        end
        if (clr_maint) begin
            nxt_maint = '0;
        end else if (shift_maint) begin
            nxt_maint = {maint_ff[maint_pkg::MAINT_LEN-2:0], sin};
        end
    end

    // Chain registers; the clock enable freezes both
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            data_ff <= '0;
            maint_ff <= '0;
        end else if (ce) begin
            data_ff <= nxt_data;
            maint_ff <= nxt_maint;
        end
    end

    assign data_tail = data_ff[maint_pkg::DATA_LEN-1];
    assign maint_tail = maint_ff[maint_pkg::MAINT_LEN-1];
    assign err_any = |err_bits;
    assign stop_hit = maint_ff[maint_pkg::STOP_EN_POS] &&
        (maint_ff[maint_pkg::CMP_POS +: maint_pkg::FUNC_W] == func_val);
    assign no_freeze = maint_ff[maint_pkg::NO_FREEZE_POS];
endmodule : maint_card

//--- design/maint_module_dev.sv
// Purpose: module end of the maintenance bus, a group of processor cards
// Assumes: controller end runs on the same clock, so no synchronisers
// Notes: the bus outputs are registered, so every answer lags one cycle
// Notes: shifting needs only the clock enable, so chains read out after a freeze
`timescale 1ns/1ps
module maint_module_dev (
    input wire logic clock,
    input wire logic rst,
    input wire logic ce,
    maint_bus_if.dev bus,
    input wire logic [maint_pkg::NUM_CARDS-1:0][maint_pkg::ERR_KINDS-1:0] err_detect,
    input wire logic [maint_pkg::NUM_CARDS-1:0][maint_pkg::STATE_W-1:0] state_in,
    output logic frozen,
    output logic [maint_pkg::NUM_CARDS-1:0] card_running
);
    // Per-card control and status
    logic [maint_pkg::NUM_CARDS-1:0] run;
    logic [maint_pkg::NUM_CARDS-1:0] shift_data;
    logic [maint_pkg::NUM_CARDS-1:0] shift_maint;
    logic [maint_pkg::NUM_CARDS-1:0] clr_data;
    logic [maint_pkg::NUM_CARDS-1:0] clr_maint;
    logic [maint_pkg::NUM_CARDS-1:0] data_tail;
    logic [maint_pkg::NUM_CARDS-1:0] maint_tail;
    logic [maint_pkg::NUM_CARDS-1:0] err_any;
    logic [maint_pkg::NUM_CARDS-1:0] stop_hit;
    logic [maint_pkg::NUM_CARDS-1:0] no_freeze;
    logic mod_error;
    logic freeze;

    // Serial answer register
    logic serial_out_ff;
    logic nxt_serial_out;

    // Event line registers
    logic error_int_ff;
    logic nxt_error_int;
    logic stop_and_ff;
    logic nxt_stop_and;
    logic stop_or_ff;
    logic nxt_stop_or;

    // User status registers
    logic frozen_ff;
    logic nxt_frozen;
    logic [maint_pkg::NUM_CARDS-1:0] running_ff;
    logic [maint_pkg::NUM_CARDS-1:0] nxt_running;

    // Card address decode, used for both shift and clear
    function automatic logic card_hit(input logic [maint_pkg::CARD_W-1:0] sel, input int idx);
        card_hit = (sel == idx[maint_pkg::CARD_W-1:0]);
    endfunction : card_hit

    // Card and chain decode, shared by the shift and the chain clear
    function automatic logic chain_hit(input logic [maint_pkg::CARD_W-1:0] sel,
        input logic chain, input int idx, input logic want);
        chain_hit = card_hit(sel, idx) && (chain == want);
    endfunction : chain_hit

    // Module-level error and freeze
    // module error line
    assign mod_error = |err_any;
    // gated freeze
    // A suppress bit on any card keeps the whole module from freezing, since the
    // cards of one module must never drift apart in time
    assign freeze = mod_error && !(|no_freeze);

    generate
        for (genvar i = 0; i < maint_pkg::NUM_CARDS; i++) begin : g_card
            assign run[i] = bus.card_clk_en[i] && !freeze;
            // shift decode
            // Data chains shift whether or not the card clock runs, so the
            // error bits stay readable after a freeze
            assign shift_data[i] = bus.shift_en &&
                chain_hit(bus.card_sel, bus.chain_sel, i, maint_pkg::CHAIN_DATA);

            // maintenance shift
            // Not gated by the card clock, so the compare chain can be
            // loaded while the processor keeps running
            assign shift_maint[i] = bus.shift_en &&
                chain_hit(bus.card_sel, bus.chain_sel, i, maint_pkg::CHAIN_MAINT);

            // module or chain clear
            // A module clear hits both chains of every card whatever the
            // address lines show
            assign clr_data[i] = bus.clr_module || (bus.clr_chain &&
                chain_hit(bus.card_sel, bus.chain_sel, i, maint_pkg::CHAIN_DATA));
            assign clr_maint[i] = bus.clr_module || (bus.clr_chain &&
                chain_hit(bus.card_sel, bus.chain_sel, i, maint_pkg::CHAIN_MAINT));

            // two chains per card
            // Each card answers on its own tails; only the selected one reaches the bus
            maint_card u_card (
                .clock(clock),
                .rst(rst),
                .ce(ce),
                .run(run[i]),
                .shift_data(shift_data[i]),
                .shift_maint(shift_maint[i]),
                .clr_data(clr_data[i]),
                .clr_maint(clr_maint[i]),
                .sin(bus.serial_in),
                .err_detect(err_detect[i]),
                .state_in(state_in[i]),
                .data_tail(data_tail[i]),
                .maint_tail(maint_tail[i]),
                .err_any(err_any[i]),
                .stop_hit(stop_hit[i]),
                .no_freeze(no_freeze[i])
            );
        end
    endgenerate

    // Serial answer: the tail is caught at the shift edge, so the controller
    // sees the bit that left the chain one cycle after it asked
    always_comb begin
        nxt_serial_out = serial_out_ff;
        // bit leaving chain
        // The last value holds between shifts, as the controller may read late
        if (bus.shift_en) begin
            if (bus.chain_sel == maint_pkg::CHAIN_MAINT) begin
                nxt_serial_out = maint_tail[bus.card_sel];
            end else begin
                nxt_serial_out = data_tail[bus.card_sel];
            end
        end
    end

    // one logical bus
    // The same registers feed either electrical bus; only buffers differ
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            serial_out_ff <= 1'h0;
        end else if (ce) begin
            serial_out_ff <= nxt_serial_out;
        end
    end

    // Event lines, registered so a long backplane sees no decode glitches
    always_comb begin
        nxt_error_int = mod_error;
        nxt_stop_and = &stop_hit;
        nxt_stop_or = |stop_hit;
    end

    // Event registers; the one-cycle lag is part of the bus contract
    // and lets the controller sample without a synchroniser
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            error_int_ff <= 1'h0;
            stop_and_ff <= 1'h0;
            stop_or_ff <= 1'h0;
        end else if (ce) begin
            error_int_ff <= nxt_error_int;
            stop_and_ff <= nxt_stop_and;
            stop_or_ff <= nxt_stop_or;
        end
    end

    // User status: freeze and per-card clocking
    always_comb begin
        // Running is reported a cycle late, like every other answer
        nxt_frozen = freeze;
        nxt_running = run;
    end

    // Status registers
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            frozen_ff <= 1'h0;
            running_ff <= '0;
        end else if (ce) begin
            frozen_ff <= nxt_frozen;
            running_ff <= nxt_running;
        end
    end

    // Outputs straight from flip-flops
    // so no bus line can glitch while cards are cleared
    assign bus.serial_out = serial_out_ff;
    assign bus.error_int = error_int_ff;
    assign bus.stop_and = stop_and_ff;
    assign bus.stop_or = stop_or_ff;
    assign frozen = frozen_ff;
    assign card_running = running_ff;
endmodule : maint_module_dev

//--- design/maint_ctrl.sv
// Purpose: controller end of the maintenance bus
// Assumes: one command at a time, accepted while cmd_ready is high
// Notes: error or stop from the module halts all cards at once
`timescale 1ns/1ps
module maint_ctrl (
    input wire logic clock,
    input wire logic rst,
    input wire logic ce,
    maint_bus_if.ctl bus,
    input wire logic cmd_valid,
    input wire logic [2:0] cmd_op,
    input wire logic [maint_pkg::CARD_W-1:0] cmd_card,
    input wire logic cmd_chain,
    input wire logic [maint_pkg::ARG_W-1:0] cmd_arg,
    output logic cmd_ready,
    output logic rd_bit,
    output logic rd_valid,
    output logic err_seen,
    output logic stop_seen,
    output logic maint_mode,
    output logic [maint_pkg::ARG_W-1:0] freq
);
    typedef enum logic [1:0] {st_idle, st_step, st_shift, st_capture} ctl_state_type;
    ctl_state_type state_ff, nxt_state;
    logic [maint_pkg::NUM_CARDS-1:0] run_ff, nxt_run, clk_en_ff, nxt_clk_en, mask;
    logic shift_ff, nxt_shift, clr_mod_ff, nxt_clr_mod, clr_chain_ff, nxt_clr_chain;
    logic chain_ff, nxt_chain, sin_ff, nxt_sin, rd_bit_ff, nxt_rd_bit, rd_valid_ff;
    logic nxt_rd_valid, err_ff, nxt_err, stop_ff, nxt_stop, mode_ff, nxt_mode;
    logic [maint_pkg::CARD_W-1:0] card_ff, nxt_card;
    logic [maint_pkg::ARG_W-1:0] freq_ff, nxt_freq;
    logic take;

    assign take = cmd_valid && (state_ff == st_idle);

    // Command decode and next state
    always_comb begin
        nxt_state = st_idle;
        nxt_run = run_ff;
        nxt_shift = 1'h0;
        nxt_clr_mod = 1'h0;
        nxt_clr_chain = 1'h0;
        nxt_chain = chain_ff;
        nxt_card = card_ff;
        nxt_sin = sin_ff;
        nxt_rd_bit = rd_bit_ff;
        nxt_rd_valid = 1'h0;
        nxt_err = err_ff;
        nxt_stop = stop_ff;
        nxt_mode = mode_ff;
        nxt_freq = freq_ff;
        mask = '0;
        mask[cmd_card] = 1'h1;
        if (!mode_ff || cmd_arg[0]) begin
            mask = '1;
        end
        case (state_ff)
            st_idle: begin
                if (take) begin
                    nxt_card = cmd_card;
                    nxt_chain = cmd_chain;
                    case (cmd_op)
                        maint_pkg::op_run: nxt_run = run_ff | mask;
                        maint_pkg::op_halt: nxt_run = run_ff & ~mask;
                        maint_pkg::op_step: nxt_state = st_step;
                        maint_pkg::op_shift: begin
                            nxt_shift = 1'h1;
                            nxt_sin = cmd_arg[0];
                            nxt_state = st_shift;
                        end
                        maint_pkg::op_clr_module: begin
                            nxt_clr_mod = 1'h1;
                            nxt_err = 1'h0;
                            nxt_stop = 1'h0;
                        end
                        maint_pkg::op_clr_chain: nxt_clr_chain = 1'h1;
                        // frequency register
                        // Code 7 with the chain select set loads the frequency instead
                        maint_pkg::op_set_mode: begin
                            if (cmd_chain) begin
                                nxt_freq = cmd_arg;
                            end else begin
                                nxt_mode = cmd_arg[0];
                            end
                        end
                        default: nxt_state = st_idle;
                    endcase
                end
            end
            st_shift: nxt_state = st_capture;
            st_capture: begin
                nxt_rd_bit = bus.serial_out;
                nxt_rd_valid = 1'h1;
            end
            default: nxt_state = st_idle;
        endcase
        // halt on event
        // Checked last, so an event in a clear or run cycle still wins
        if (bus.error_int) begin
            nxt_err = 1'h1;
            nxt_run = '0;
        end
        if (bus.stop_or) begin
            nxt_stop = 1'h1;
            nxt_run = '0;
        end
        nxt_clk_en = nxt_run;
        if (nxt_state == st_step) begin
            nxt_clk_en = nxt_run | mask;
        end
    end

    // Controller registers
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            state_ff <= st_idle;
            run_ff <= '0;
            clk_en_ff <= '0;
            shift_ff <= 1'h0;
            clr_mod_ff <= 1'h0;
            clr_chain_ff <= 1'h0;
            chain_ff <= 1'h0;
            card_ff <= '0;
            sin_ff <= 1'h0;
            rd_bit_ff <= 1'h0;
            rd_valid_ff <= 1'h0;
            err_ff <= 1'h0;
            stop_ff <= 1'h0;
            mode_ff <= 1'h0;
            freq_ff <= maint_pkg::FREQ_RESET;
        end else if (ce) begin
            state_ff <= nxt_state;
            run_ff <= nxt_run;
            clk_en_ff <= nxt_clk_en;
            shift_ff <= nxt_shift;
            clr_mod_ff <= nxt_clr_mod;
            clr_chain_ff <= nxt_clr_chain;
            chain_ff <= nxt_chain;
            card_ff <= nxt_card;
            sin_ff <= nxt_sin;
            rd_bit_ff <= nxt_rd_bit;
            rd_valid_ff <= nxt_rd_valid;
            err_ff <= nxt_err;
            stop_ff <= nxt_stop;
            mode_ff <= nxt_mode;
            freq_ff <= nxt_freq;
        end
    end

    assign bus.card_clk_en = clk_en_ff;
    assign bus.shift_en = shift_ff;
    assign bus.clr_module = clr_mod_ff;
    assign bus.clr_chain = clr_chain_ff;
    assign bus.chain_sel = chain_ff;
    assign bus.card_sel = card_ff;
    assign bus.serial_in = sin_ff;
    assign cmd_ready = (state_ff == st_idle);
    assign rd_bit = rd_bit_ff;
    assign rd_valid = rd_valid_ff;
    assign err_seen = err_ff;
    assign stop_seen = stop_ff;
    assign maint_mode = mode_ff;
    assign freq = freq_ff;
endmodule : maint_ctrl

//--- verification/maint_monitor.sv
// Purpose: bus checker between controller end and module end
// Assumes: one clock, reset active high
// Notes: module-side ports are judged by the bench instead
`timescale 1ns/1ps
module maint_monitor (
    input wire logic clock,
    input wire logic rst,
    input wire logic [maint_pkg::NUM_CARDS-1:0] card_clk_en,
    input wire logic shift_en,
    input wire logic clr_module,
    input wire logic clr_chain,
    input wire logic serial_out,
    input wire logic error_int,
    input wire logic stop_and,
    input wire logic stop_or
);
    logic wipe;
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (rst);
    // Bus commands that may clear or shift chain contents
    assign wipe = clr_module | clr_chain | shift_en;
    chk_and_in_or: assert property (stop_and |-> stop_or)
        else $error("and stop without or stop");
    chk_error_halts: assert property ($rose(error_int) |-> ##[1:2] (card_clk_en == '0))
        else $error("clocks on after error");
    chk_stop_halts: assert property ($rose(stop_or) |-> ##[1:2] (card_clk_en == '0))
        else $error("clocks on after stop");
    chk_shift_single: assert property (shift_en |=> (!shift_en) [*2])
        else $error("shift pulse too long");
    chk_clr_pulse: assert property (clr_module |=> !clr_module)
        else $error("module clear held");
    chk_chain_pulse: assert property (clr_chain |=> !clr_chain)
        else $error("chain clear held");
    chk_out_on_shift: assert property ($changed(serial_out) |-> $past(wipe))
        else $error("serial out moved without shift");
    chk_err_sticky: assert property ($fell(error_int) |-> $past(wipe) || $past(wipe, 2))
        else $error("error dropped without clear");
endmodule : maint_monitor

//--- verification/maint_chain_error_stop_clock_tb.sv
// Purpose: bench for controller and module ends joined by the bus
// Assumes: both ends on one 10 MHz clock
// Notes: random words come from a fixed-seed xorshift
`timescale 1ns/1ps
module maint_chain_error_stop_clock_tb;
    logic clock, rst, ce, cmd_valid, cmd_chain, cmd_ready, rd_bit, rd_valid, o;
    logic err_seen, stop_seen, maint_mode, frozen, eint, sor, sand;
    logic [2:0] cmd_op;
    logic [maint_pkg::CARD_W-1:0] cmd_card;
    logic [maint_pkg::ARG_W-1:0] cmd_arg, freq;
    logic [maint_pkg::NUM_CARDS-1:0] card_running, en;
    logic [maint_pkg::NUM_CARDS-1:0][maint_pkg::ERR_KINDS-1:0] err_detect;
    logic [maint_pkg::NUM_CARDS-1:0][maint_pkg::STATE_W-1:0] state_in;
    logic [31:0] seed;
    logic [15:0] v;
    logic [7:0] cv;
    int n_fail = 0;
    int checks_done = 0;

    maint_bus_if u_maint_bus_if ();
    maint_module_dev u_maint_module_dev (.clock(clock), .rst(rst), .ce(ce),
        .bus(u_maint_bus_if.dev), .err_detect(err_detect), .state_in(state_in),
        .frozen(frozen), .card_running(card_running));
    maint_ctrl u_maint_ctrl (.clock(clock), .rst(rst), .ce(ce), .bus(u_maint_bus_if.ctl),
        .cmd_valid(cmd_valid), .cmd_op(cmd_op), .cmd_card(cmd_card), .cmd_chain(cmd_chain),
        .cmd_arg(cmd_arg), .cmd_ready(cmd_ready), .rd_bit(rd_bit), .rd_valid(rd_valid),
        .err_seen(err_seen), .stop_seen(stop_seen), .maint_mode(maint_mode), .freq(freq));
    maint_monitor u_maint_monitor (.clock(clock), .rst(rst),
        .card_clk_en(u_maint_bus_if.card_clk_en), .shift_en(u_maint_bus_if.shift_en),
        .clr_module(u_maint_bus_if.clr_module), .clr_chain(u_maint_bus_if.clr_chain),
        .serial_out(u_maint_bus_if.serial_out), .error_int(u_maint_bus_if.error_int),
        .stop_and(u_maint_bus_if.stop_and), .stop_or(u_maint_bus_if.stop_or));

    // Short views of the bus lines the bench compares
    assign en = u_maint_bus_if.card_clk_en;
    assign eint = u_maint_bus_if.error_int;
    assign sor = u_maint_bus_if.stop_or;
    assign sand = u_maint_bus_if.stop_and;

    always #50 clock = ~clock;

    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] r;
        r = s ^ (s << 13);
        r = r ^ (r >> 17);
        return r ^ (r << 5);
    endfunction : xs

    // Expected stop: equal compare with enable set
    function automatic logic hit(input logic [7:0] c, input logic e, input logic [7:0] cnt);
        return e && (c == cnt);
    endfunction : hit

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_fail++;
            $display("BAD t=%0t seen %h want %h", $time, seen, exp);
        end
    endtask : chk

    // Hold the request until the edge that takes it
    task automatic cmd(input logic [2:0] op, input logic [maint_pkg::CARD_W-1:0] card,
        input logic ch, input logic [7:0] arg);
        int k;
        @(negedge clock);
        cmd_valid = 1'h1;
        cmd_op = op;
        cmd_card = card;
        cmd_chain = ch;
        cmd_arg = arg;
        k = 0;
        while (cmd_ready !== 1'h1 && k < 20) begin
            @(negedge clock);
            k++;
        end
        @(negedge clock);
        cmd_valid = 1'h0;
    endtask : cmd

    task automatic sh(input logic [maint_pkg::CARD_W-1:0] card, input logic ch,
        input logic b, output logic q);
        int k;
        cmd(maint_pkg::op_shift, card, ch, {7'h00, b});
        k = 0;
        while (rd_valid !== 1'h1 && k < 8) begin
            @(negedge clock);
            k++;
        end
        q = rd_bit;
    endtask : sh

    // Last bit in lands at bit 0, so send the word top first
    task automatic ld(input logic [maint_pkg::CARD_W-1:0] card, input logic [9:0] w);
        logic q;
        for (int i = 9; i >= 0; i--) begin
            sh(card, maint_pkg::CHAIN_MAINT, w[i], q);
        end
    endtask : ld

    task automatic rd(input logic [maint_pkg::CARD_W-1:0] card, input logic ch,
        input int n, output logic [15:0] w);
        logic q;
        w = 16'h0000;
        for (int i = 0; i < n; i++) begin
            sh(card, ch, 1'h0, q);
            w = {w[14:0], q};
        end
    endtask : rd

    task automatic final_report();
        if (n_fail == 0 && checks_done > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : final_report

    // Watchdog well beyond the several hundred cycles needed
    initial begin
        repeat (20000) @(posedge clock);
        n_fail++;
        final_report();
    end

    initial begin
        clock = 1'h0;
        rst = 1'h1;
        ce = 1'h1;
        cmd_valid = 1'h0;
        cmd_op = 3'h0;
        cmd_card = 1'h0;
        cmd_chain = 1'h0;
        cmd_arg = 8'h00;
        err_detect = 8'h00;
        seed = xs(32'h4992);
        state_in = seed[7:0];
        repeat (12) @(negedge clock);
        rst = 1'h0;
        chk({cmd_ready, maint_mode, err_seen, stop_seen, en, eint, sor, freq}, 16'h8000);
        seed = xs(seed);
        ld(seed[10], seed[9:0]);
        rd(seed[10], maint_pkg::CHAIN_MAINT, 10, v);
        chk(v, {6'h00, seed[9:0]});
        ld(seed[10], seed[9:0] | 10'h001);
        cmd(maint_pkg::op_clr_chain, seed[10], maint_pkg::CHAIN_MAINT, 8'h00);
        rd(seed[10], maint_pkg::CHAIN_MAINT, 10, v);
        chk(v, 16'h0000);
        cmd(maint_pkg::op_clr_module, 1'h0, 1'h0, 8'h00);
        for (int i = 0; i < 2; i++) begin
            seed = xs(seed);
            cv = (i == 0) ? (seed[7:0] | 8'h01) : 8'h00;
            cmd(maint_pkg::op_clr_chain, 1'h0, maint_pkg::CHAIN_MAINT, 8'h00);
            ld(1'h0, {2'h1, cv});
            repeat (2) @(negedge clock);
            chk({sand, sor}, {1'h0, hit(cv, 1'h1, 8'h00)});
        end
        ld(1'h1, 10'h100);
        repeat (2) @(negedge clock);
        chk({sand, sor}, 2'h3);
        cmd(maint_pkg::op_run, 1'h0, 1'h0, 8'h01);
        repeat (2) @(negedge clock);
        chk({en, stop_seen}, 3'h1);
        // The stop line lags the clear, so a second clear is needed for the flag
        cmd(maint_pkg::op_clr_module, 1'h0, 1'h0, 8'h00);
        repeat (2) @(negedge clock);
        cmd(maint_pkg::op_clr_module, 1'h0, 1'h0, 8'h00);
        repeat (3) @(negedge clock);
        chk({sor, stop_seen}, 2'h0);
        seed = xs(seed);
        cmd(maint_pkg::op_run, 1'h0, 1'h0, 8'h01);
        @(negedge clock);
        chk({en, card_running}, 4'hF);
        err_detect[1][seed[1:0]] = 1'h1;
        @(negedge clock);
        err_detect = 8'h00;
        repeat (3) @(negedge clock);
        chk({eint, en, frozen, err_seen}, 5'h13);
        cmd(maint_pkg::op_clr_chain, 1'h0, maint_pkg::CHAIN_DATA, 8'h00);
        repeat (4) @(negedge clock);
        chk(eint, 1'h1);
        rd(1'h1, maint_pkg::CHAIN_DATA, 16, v);
        chk(v[15:8], {state_in[1], 4'h1 << seed[1:0]});
        cmd(maint_pkg::op_clr_module, 1'h0, 1'h0, 8'h00);
        repeat (3) @(negedge clock);
        chk({eint, frozen, err_seen}, 3'h0);
        ld(1'h0, 10'h2FF);
        ld(1'h1, 10'h2FF);
        cmd(maint_pkg::op_run, 1'h0, 1'h0, 8'h01);
        @(negedge clock);
        err_detect[0][0] = 1'h1;
        @(negedge clock);
        err_detect = 8'h00;
        repeat (3) @(negedge clock);
        chk({eint, frozen}, 2'h2);
        cmd(maint_pkg::op_clr_module, 1'h0, 1'h0, 8'h00);
        // single steps per card in maintenance mode
        cmd(maint_pkg::op_set_mode, 1'h0, 1'h0, 8'h01);
        @(negedge clock);
        chk(maint_mode, 1'h1);
        for (int c = 0; c < 2; c++) begin
            cmd(maint_pkg::op_step, c[0], 1'h0, 8'h00);
            chk(en, 2'h1 << c);
            @(negedge clock);
            chk(en, 2'h0);
        end
        cmd(maint_pkg::op_run, 1'h1, 1'h0, 8'h00);
        @(negedge clock);
        chk(en, 2'h2);
        cmd(maint_pkg::op_halt, 1'h0, 1'h0, 8'h01);
        @(negedge clock);
        chk(en, 2'h0);
        cmd(maint_pkg::op_set_mode, 1'h0, 1'h0, 8'h00);
        cmd(maint_pkg::op_run, 1'h0, 1'h0, 8'h00);
        @(negedge clock);
        chk(en, 2'h3);
        sh(1'h0, maint_pkg::CHAIN_MAINT, 1'h0, o);
        chk({en, card_running}, 4'hF);
        seed = xs(seed);
        cmd(maint_pkg::op_set_mode, 1'h0, 1'h1, seed[7:0]);
        chk({maint_mode, freq}, {1'h0, seed[7:0]});
        final_report();
    end
endmodule : maint_chain_error_stop_clock_tb
